// ==== unb_consts.svh ====
`ifndef UNB_CONSTS_SVH
`define UNB_CONSTS_SVH

// ----------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------
`define UNB_ADDR_CTRL 12'h000
`define UNB_ADDR_STATUS 12'h004
`define UNB_ADDR_MASK 12'h008
`define UNB_ADDR_TXBUF 12'h00C
`define UNB_ADDR_RXBUF 12'h010
// ctrl fields
`define UNB_CTRL_MODE 0
`define UNB_CTRL_DOUBLE 1
`define UNB_CTRL_FILTER 2
`define UNB_CTRL_TX9 3
`define UNB_CTRL_TXSRC 4
`define UNB_CTRL_RXSRC 5
`define UNB_CTRL_RXEN 6
// status fields
`define UNB_ST_TXDONE 0
`define UNB_ST_RXDONE 1
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define UNB_DIV_DOUBLE 6'h1F
`define UNB_DIV_SINGLE 6'h3F
`define UNB_SAMPLE_A 4'h7
`define UNB_SAMPLE_B 4'h8
`define UNB_SAMPLE_C 4'h9
`define UNB_RX_PRESET 9'h1FF
`endif

// ==== unb_pkg.sv ====
package unb_pkg;
  typedef enum logic [2:0] {
    UNB_TX_IDLE = 3'b001,
    UNB_TX_WAIT = 3'b010,
    UNB_TX_SEND = 3'b100
  } unb_tx_state_t;
  typedef enum logic [2:0] {
    UNB_RX_HUNT = 3'b001,
    UNB_RX_BITS = 3'b010,
    UNB_RX_HOLD = 3'b100
  } unb_rx_state_t;
endpackage

// ==== unb_uart.sv ====
`include "unb_consts.svh"
module unb_uart
  import unb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer1_overflow,
  input wire logic timer2_overflow,
  input wire logic rxd,
  output logic txd,
  output logic irq
);
  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  logic [6:0] ctrl_q;
  logic [1:0] status_q;
  logic [1:0] mask_q;
  logic [7:0] serial_buffer_q;
  logic rx_ninth_bit_q;
  logic tx_done_set;
  logic rx_done_set;
  logic [7:0] rx_data_d;
  logic rx_nine_d;
  logic acc;
  logic wr;
  logic txbuf_wr;
  logic mapped;

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  // the vote points must sit inside one sixteen-state bit time and in order,
  // otherwise the majority would mix samples of two neighbouring bits
  if (`UNB_SAMPLE_C > 4'hE) begin : g_chk_late
    $error("sample points must end before the last counter state");
  end
  if (!(`UNB_SAMPLE_A < `UNB_SAMPLE_B && `UNB_SAMPLE_B < `UNB_SAMPLE_C))
  begin : g_chk_order
    $error("sample points must rise strictly");
  end
  // the receive preset must be all ones so the start bit walks up alone
  if (`UNB_RX_PRESET != 9'h1FF) begin : g_chk_preset
    $error("receive preset must be all ones");
  end
  // status and mask share one layout; the two flags must be distinct
  if (`UNB_ST_TXDONE == `UNB_ST_RXDONE) begin : g_chk_flags
    $error("status flags must not overlap");
  end

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  // a register changes only at the edge that completes the access, so a
  // long setup phase can never write twice
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign txbuf_wr = wr && (paddr == `UNB_ADDR_TXBUF);
  assign mapped = (paddr == `UNB_ADDR_CTRL) || (paddr == `UNB_ADDR_STATUS) ||
                  (paddr == `UNB_ADDR_MASK) || (paddr == `UNB_ADDR_TXBUF) ||
                  (paddr == `UNB_ADDR_RXBUF);

  // apb answers in the second access cycle: pready pulses once per transfer
  always_ff @(posedge sys_clk) begin
    if (srst || !(psel && penable) || pready) begin
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && penable && !pready && !mapped;
    end
  end

  // read data registered with pready
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prdata <= 32'h0;
    end else if (psel && penable && !pready && !pwrite) begin
      case (paddr)
        `UNB_ADDR_CTRL: prdata <= {25'h0, ctrl_q};
        `UNB_ADDR_STATUS: prdata <= {30'h0, status_q};
        `UNB_ADDR_MASK: prdata <= {30'h0, mask_q};
        `UNB_ADDR_RXBUF: prdata <= {23'h0, rx_ninth_bit_q, serial_buffer_q};
        default: prdata <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_q <= 7'h0;
    end else if (wr && paddr == `UNB_ADDR_CTRL) begin
      ctrl_q <= pwdata[6:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mask_q <= 2'h0;
    end else if (wr && paddr == `UNB_ADDR_MASK) begin
      mask_q <= pwdata[1:0];
    end
  end

  // sticky flags: a hardware set in the clearing cycle wins
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      status_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == 0 && tx_done_set) || (i == 1 && rx_done_set)) begin
          status_q[i] <= 1'b1;
        end else if (wr && paddr == `UNB_ADDR_STATUS && pwdata[i]) begin
          status_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_q & mask_q);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      serial_buffer_q <= 8'h0;
      rx_ninth_bit_q <= 1'b0;
    end else if (rx_done_set) begin
      serial_buffer_q <= rx_data_d;
      rx_ninth_bit_q <= rx_nine_d;
    end
  end

  // ----------------------------------------------------------------------
  // baud ticks (sixteen per bit)
  // ----------------------------------------------------------------------
  logic [5:0] osc_div_q;
  logic osc_tick;
  logic tx_tick;
  logic rx_tick;

  // fixed mode: osc/2 or osc/4 ticks, then /16 gives osc/32 or osc/64
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      osc_div_q <= 6'h0;
    end else begin
      osc_div_q <= osc_div_q + 6'h1;
    end
  end
  assign osc_tick = ctrl_q[`UNB_CTRL_DOUBLE] ? osc_div_q[0]
                                             : (osc_div_q[1:0] == 2'h3);
  // variable mode takes timer overflows; timer 1 setup is software's job
  assign tx_tick = !ctrl_q[`UNB_CTRL_MODE] ? osc_tick :
                   (ctrl_q[`UNB_CTRL_TXSRC] ? timer2_overflow
                                            : timer1_overflow);
  assign rx_tick = !ctrl_q[`UNB_CTRL_MODE] ? osc_tick :
                   (ctrl_q[`UNB_CTRL_RXSRC] ? timer2_overflow
                                            : timer1_overflow);

  // ----------------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------------
  // the shifter holds nine bits: eight data bits and the ninth bit; the
  // stop bit enters on top at the first shift and zeros follow it, so the
  // end of a frame is seen from the shifter and tx_first_done_q without a bit counter
  unb_tx_state_t tx_state_q;
  logic [3:0] tx_div_q;
  logic [8:0] tx_shift_q;
  logic tx_bit_end;
  logic tx_data_on_q;
  logic tx_first_done_q;
  logic tx_last_bit;

  // free-running divide-by-16: bit edges follow it, not the buffer write
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_div_q <= 4'h0;
    end else if (tx_tick) begin
      tx_div_q <= tx_div_q + 4'h1;
    end
  end
  assign tx_bit_end = tx_tick && (tx_div_q == 4'hF);

  // marks that the stop bit is already inside the shifter
  always_ff @(posedge sys_clk) begin
    if (srst || tx_state_q != UNB_TX_SEND) begin
      tx_first_done_q <= 1'b0;
    end else if (tx_bit_end && tx_data_on_q) begin
      tx_first_done_q <= 1'b1;
    end
  end

  // ninth bit at the output, stop bit just above it, zeros beyond
  assign tx_last_bit = tx_first_done_q && (tx_shift_q[8:1] == 8'h01);

  // transmit sequencer: one bit time per rollover of the divider
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_state_q <= UNB_TX_IDLE;
      tx_shift_q <= 9'h0;
      tx_data_on_q <= 1'b0;
      txd <= 1'b1;
    end else begin
      case (tx_state_q)
        UNB_TX_IDLE: begin
          txd <= 1'b1;
          if (txbuf_wr) begin
            // ninth bit rides on top of the data byte
            tx_shift_q <= {ctrl_q[`UNB_CTRL_TX9], pwdata[7:0]};
            tx_state_q <= UNB_TX_WAIT;
          end
        end
        UNB_TX_WAIT: begin
          if (tx_bit_end) begin
            txd <= 1'b0;
            tx_data_on_q <= 1'b0;
            tx_state_q <= UNB_TX_SEND;
          end
        end
        UNB_TX_SEND: begin
          if (tx_bit_end) begin
            if (!tx_data_on_q) begin
              tx_data_on_q <= 1'b1;
              txd <= tx_shift_q[0];
            end else if (tx_last_bit) begin
              // last shift leaves only the stop bit at the output
              tx_shift_q <= {1'b0, tx_shift_q[8:1]};
              txd <= 1'b1;
              tx_state_q <= UNB_TX_IDLE;
            end else begin
              // first shift loads the stop bit on top, later shifts zeros
              tx_shift_q <= {!tx_first_done_q, tx_shift_q[8:1]};
              txd <= tx_shift_q[1];
            end
          end
        end
        default: tx_state_q <= UNB_TX_IDLE;
      endcase
    end
  end

  // done flag rises at the eleventh rollover after the buffer write:
  // start, eight data bits, ninth bit, then the stop bit begins here
  assign tx_done_set = (tx_state_q == UNB_TX_SEND) && tx_bit_end &&
                       tx_data_on_q && tx_last_bit;

  // ----------------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------------
  unb_rx_state_t rx_state_q;
  logic [3:0] rx_div_q;
  logic [8:0] rx_shift_q;
  logic [2:0] rx_samp_q;
  logic rxd_prev_q;
  logic rx_start_ok_q;
  logic rx_vote;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rxd_prev_q <= 1'b1;
    end else if (rx_tick) begin
      rxd_prev_q <= rxd;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rx_samp_q <= 3'h0;
    end else if (rx_tick && (rx_div_q == `UNB_SAMPLE_A ||
               rx_div_q == `UNB_SAMPLE_B || rx_div_q == `UNB_SAMPLE_C)) begin
      rx_samp_q <= {rx_samp_q[1:0], rxd};
    end
  end
  assign rx_vote = (rx_samp_q[0] & rx_samp_q[1]) | (rx_samp_q[1] &
                   rx_samp_q[2]) | (rx_samp_q[0] & rx_samp_q[2]);

  // bits enter from the right, so the first data bit ends up highest;
  // the buffer wants it at bit 0, hence the reversal
  for (genvar b = 0; b < 8; b++) begin : g_rx_rev
    assign rx_data_d[b] = rx_shift_q[7 - b];
  end
  assign rx_nine_d = rx_vote;
  // start bit at left: ninth bit voted without a shift, filtered load
  assign rx_done_set = (rx_state_q == UNB_RX_BITS) && rx_tick &&
                       rx_div_q == 4'hF && rx_start_ok_q && !rx_shift_q[8] &&
                       !status_q[`UNB_ST_RXDONE] &&
                       (!ctrl_q[`UNB_CTRL_FILTER] || rx_vote);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rx_state_q <= UNB_RX_HUNT;
      rx_div_q <= 4'h0;
      rx_shift_q <= `UNB_RX_PRESET;
      rx_start_ok_q <= 1'b0;
    end else if (rx_tick) begin
      rx_div_q <= rx_div_q + 4'h1;
      case (rx_state_q)
        UNB_RX_HUNT: begin
          if (ctrl_q[`UNB_CTRL_RXEN] && rxd_prev_q && !rxd) begin
            rx_div_q <= 4'h0;
            rx_shift_q <= `UNB_RX_PRESET;
            rx_start_ok_q <= 1'b0;
            rx_state_q <= UNB_RX_BITS;
          end
        end
        UNB_RX_BITS: begin
          if (rx_div_q == 4'hF) begin
            if (!rx_start_ok_q) begin
              if (rx_vote) begin
                rx_state_q <= UNB_RX_HUNT;
              end else begin
                rx_start_ok_q <= 1'b1;
                rx_shift_q <= {rx_shift_q[7:0], 1'b0};
              end
            end else if (!rx_shift_q[8]) begin
              rx_state_q <= UNB_RX_HOLD;
            end else begin
              rx_shift_q <= {rx_shift_q[7:0], rx_vote};
            end
          end
        end
        UNB_RX_HOLD: begin
          if (rx_div_q == 4'hF) begin
            rx_state_q <= UNB_RX_HUNT;
          end
        end
        default: rx_state_q <= UNB_RX_HUNT;
      endcase
    end
  end
endmodule

// ==== unb_uart_checker.sv ====
module unb_uart_checker
  import unb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer1_overflow,
  input wire logic timer2_overflow,
  input wire logic rxd,
  input wire logic txd,
  input wire logic irq
);
  logic [6:0] ctrl_q;
  logic [11:0] low_q;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // shadow of the control word, taken from completed bus writes
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_q <= 7'h00;
    end else if (psel && penable && pready && pwrite && paddr == 12'h000) begin
      ctrl_q <= pwdata[6:0];
    end
  end
  // length of the present low run on the output pin
  always_ff @(posedge sys_clk) begin
    if (txd) begin
      low_q <= 12'h000;
    end else begin
      low_q <= low_q + 12'h001;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  ready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late for access");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  err_read_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  idle_after_reset_a: assert property ($fell(srst) |-> txd && !irq)
    else $error("output not idle after reset");
  tx_start_hold_a: assert property ($fell(txd) |-> !txd [*8])
    else $error("start bit too short");
  low_run_fixed_a: assert property ($rose(txd) && !ctrl_q[0] |->
    (ctrl_q[1] ? low_q[4:0] == 5'h00 : low_q[5:0] == 6'h00))
    else $error("low run not whole bit times");
  cover property ($fell(txd));
  cover property ($rose(irq));
  cover property (pslverr);
endmodule
bind unb_uart unb_uart_checker i_chk (.sys_clk(sys_clk), .srst(srst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer1_overflow(timer1_overflow), .timer2_overflow(timer2_overflow),
  .rxd(rxd), .txd(txd), .irq(irq));

// ==== unb_line_model.sv ====
module unb_line_model (
  input wire logic sys_clk,
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  int bit_clks = 32;
  logic [9:0] got;
  initial rxd = 1'b1;
  // one frame lsb first; a short start models a line glitch
  task automatic send(input logic [8:0] v, input logic [7:0] start_len);
    rxd <= 1'b0;
    repeat (start_len) @(posedge sys_clk);
    for (int i = 0; i < 10; i++) begin
      rxd <= (i < 9) ? v[i] : 1'b1;
      repeat (bit_clks) @(posedge sys_clk);
    end
  endtask
  // sample mid bit; got[9] holds the stop level
  always begin
    @(negedge txd);
    repeat (bit_clks / 2) @(posedge sys_clk);
    for (int i = 0; i < 10; i++) begin
      repeat (bit_clks) @(posedge sys_clk);
      got[i] = txd;
    end
  end
endmodule

// ==== tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic err;
  } unb_row_t;
  typedef struct packed {logic [6:0] c; logic [7:0] b; logic [7:0] k;} unb_tx_t;
  typedef struct packed {
    logic [6:0] c; logic [8:0] f; logic [7:0] s; logic x; logic [8:0] e;
    logic clr;
  } unb_rx_t;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic t1 = 1'b0;
  logic t2 = 1'b0;
  logic [1:0] t1_cnt = 2'h0;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, rxd, txd, irq, rerr;
  int num_errors = 0;
  int total_checks = 0;
  int n;
  unb_row_t rows [8] = '{'{0, 12'h000, 0, 0, 0}, '{0, 12'h004, 0, 0, 0},
    '{0, 12'h008, 0, 0, 0}, '{0, 12'h010, 0, 0, 0},
    '{1, 12'h000, 32'h7F, 0, 0}, '{0, 12'h000, 0, 32'h7F, 0},
    '{0, 12'h020, 0, 0, 1}, '{1, 12'h020, 32'h5, 0, 1}};
  unb_tx_t tx [4] = '{'{7'h0A, 8'hA5, 8'd32}, '{7'h00, 8'h3C, 8'd64},
    '{7'h19, 8'h81, 8'd32}, '{7'h01, 8'h66, 8'd48}};
  unb_rx_t rx [6] = '{'{7'h42, 9'h15A, 8'd32, 1, 9'h15A, 0},
    '{7'h42, 9'h0A0, 8'd32, 1, 9'h15A, 1},
    '{7'h46, 9'h0C3, 8'd32, 0, 9'h15A, 1},
    '{7'h46, 9'h1C3, 8'd32, 1, 9'h1C3, 1},
    '{7'h42, 9'h1FF, 8'd4, 0, 9'h1C3, 1},
    '{7'h42, 9'h03C, 8'd32, 1, 9'h03C, 1}};
  unb_uart i_dut (.sys_clk(sys_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer1_overflow(t1), .timer2_overflow(t2), .rxd(rxd), .txd(txd),
    .irq(irq));
  unb_line_model i_line (.sys_clk(sys_clk), .txd(txd), .rxd(rxd));
  always #2.5 sys_clk = ~sys_clk;
  // timer 2 fires every 2 clocks, timer 1 every 3, so a wrong pick shows
  always @(posedge sys_clk) begin
    t1_cnt <= (t1_cnt == 2'h2) ? 2'h0 : t1_cnt + 2'h1;
    t1 <= (t1_cnt == 2'h2);
    t2 <= ~t2;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // idle cycle after release so no signal is driven twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdata = prdata;
    rerr = pslverr;
    if (k >= 20) check(32'h1, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic conclude();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) check(rdata, rows[i].e);
      check({31'h0, rerr}, {31'h0, rows[i].err});
    end
    foreach (tx[i]) begin
      i_line.bit_clks = tx[i].k;
      apb(1'b1, 12'h000, {25'h0, tx[i].c});
      apb(1'b1, 12'h008, 32'h1);
      apb(1'b1, 12'h00C, {24'h0, tx[i].b});
      n = 0;
      while (irq !== 1'b1 && n < 1500) begin
        @(posedge sys_clk);
        n++;
      end
      check({31'h0, n >= 10 * tx[i].k - 2 && n <= 11 * tx[i].k + 8}, 1);
      repeat (2 * tx[i].k) @(posedge sys_clk);
      check({22'h0, i_line.got}, {23'h1, tx[i].c[3], tx[i].b});
      apb(1'b1, 12'h004, 32'h3);
      // irq lags the status by one registered cycle
      @(posedge sys_clk);
      check({31'h0, irq}, 32'h0);
    end
    // masked event: status sets but the interrupt stays low
    i_line.bit_clks = 32;
    apb(1'b1, 12'h000, 32'h2);
    apb(1'b1, 12'h008, 32'h2);
    apb(1'b1, 12'h00C, 32'h11);
    repeat (400) @(posedge sys_clk);
    check({31'h0, irq}, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    check(rdata, 32'h1);
    apb(1'b1, 12'h004, 32'h1);
    foreach (rx[i]) begin
      apb(1'b1, 12'h000, {25'h0, rx[i].c});
      i_line.send(rx[i].f, rx[i].s);
      repeat (64) @(posedge sys_clk);
      check({31'h0, irq}, {31'h0, rx[i].x});
      apb(1'b0, 12'h004, 32'h0);
      check(rdata, {30'h0, rx[i].x, 1'b0});
      apb(1'b0, 12'h010, 32'h0);
      check(rdata, {23'h0, rx[i].e});
      if (rx[i].clr) apb(1'b1, 12'h004, 32'h2);
    end
    // reset in mid frame must return the pin to idle
    apb(1'b1, 12'h00C, 32'h00);
    repeat (100) @(posedge sys_clk);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    check({31'h0, txd}, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    check(rdata, 32'h0);
    conclude();
  end
endmodule
